// ===== hdl/urx_pkg.sv
// Notes on behaviour
// RULE_01: pending flag set while enabled and FIFO nonempty
// RULE_02: pending flag is read only
// RULE_03: pending ignores irq enables; irq needs all three
// RULE_04: framing error bit stored per character
// RULE_05: status shows oldest character; data read advances
// RULE_06: framing error never stops reception
// RULE_07: port disable clears framing; rx disable keeps it
// RULE_08: framing error alone raises no interrupt
// RULE_09: third full character with FIFO full sets overrun
// RULE_10: during overrun old data readable, nothing accepted
// RULE_11: overrun clears only by rx or port disable
// RULE_12: nine bit mode shifts nine bits, ninth shown
// RULE_13: software reads ninth bit before data
// RULE_14: software reads framing status before data
// RULE_15: address mode keeps only ninth-bit-set characters
// RULE_16: software toggles address mode around messages
// RULE_17: software enables reception last in setup
// RULE_18: transfer into buffer sets pending, may interrupt
// RULE_19: address mode characters read with ninth bit one
// RULE_20: software clears address mode once addressed
// RULE_21: all-error FIFO keeps framing status set on reads
// RULE_22: data read pops entry with its status bits
package urx_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [3:0] URX_ADDR_CTRL    = 4'h0; // control and status
  localparam logic [3:0] URX_ADDR_DATA    = 4'h4; // received data, read pops
  localparam logic [3:0] URX_ADDR_IRQ     = 4'h8; // interrupt enables and flag
  localparam logic [3:0] URX_ADDR_BAUD    = 4'hC; // baud divisor
  // ctrl register bit positions
  localparam int URX_B_PORT_EN   = 7; // serial port enable
  localparam int URX_B_NINE_SEL  = 6; // nine bit select
  localparam int URX_B_RX_EN     = 4; // continuous rx enable
  localparam int URX_B_ADDR_DET  = 3; // address detect enable
  localparam int URX_B_FRM_ERR   = 2; // frame error status, ro
  localparam int URX_B_OVERRUN   = 1; // overrun flag, ro
  localparam int URX_B_NINTH     = 0; // ninth bit, ro
  // irq register bit positions
  localparam int URX_B_GLOBAL_IE = 7; // global irq enable
  localparam int URX_B_PERIPH_IE = 6; // peripheral irq enable
  localparam int URX_B_RX_IE     = 5; // rx irq enable
  localparam int URX_B_PEND      = 4; // pending flag, ro
  // reset values
  localparam logic [7:0]  URX_CTRL_RST = 8'h00;
  localparam logic [2:0]  URX_IRQ_RST  = 3'h0;
  localparam logic [15:0] URX_BAUD_RST = 16'h0043; // about 115200 baud at 16x
  // timing
  localparam int URX_OVS       = 16; // sample ticks per bit
  localparam int URX_MID       = 7;  // tick index at mid-bit
  localparam int URX_FIFO_DEPTH = 2; // characters held
  localparam int URX_W          = 10; // data, ninth bit, frame error
endpackage

// ===== hdl/urx_baud.sv
`timescale 1ns/1ns
// ****************************************
// oversampling tick divider
// ****************************************
module urx_baud
  import urx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,     // counts only while port enabled
  input  wire logic [15:0] divisor, // ticks every divisor+1 cycles
  output logic             tick
);
  logic [15:0] cnt_q; // down counter

  // reload on zero, pulse one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= divisor;
      tick  <= 1'b0;
    end
    else if (cnt_q == 16'h0000)
    begin
      cnt_q <= divisor;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q - 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule

// ===== hdl/urx_fifo.sv
`timescale 1ns/1ns
// ****************************************
// two entry character fifo
// ****************************************
module urx_fifo
  import urx_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                flush,  // port disable empties it
  input  wire logic                push,
  input  wire logic [URX_W-1:0]    wdata,
  input  wire logic                pop,
  output logic [URX_W-1:0]         rdata,  // oldest entry
  output logic                     empty,
  output logic                     full
);
  logic [URX_W-1:0] mem_q [URX_FIFO_DEPTH]; // entries
  logic             rp_q;                    // read pointer
  logic             wp_q;                    // write pointer
  logic [1:0]       cnt_q;                   // occupancy
  logic             do_push;
  logic             do_pop;

  assign empty   = (cnt_q == 2'd0);
  assign full    = (cnt_q == 2'd2);
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign rdata   = mem_q[rp_q]; // status rides with oldest entry

  // pointers and count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rp_q  <= 1'b0;
      wp_q  <= 1'b0;
      cnt_q <= 2'd0;
    end
    else if (flush)
    begin
      rp_q  <= 1'b0;
      wp_q  <= 1'b0;
      cnt_q <= 2'd0;
    end
    else
    begin
      if (do_pop)
        rp_q <= ~rp_q; // RULE_22
      if (do_push)
        wp_q <= ~wp_q;
      cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  // storage cleared on flush so stale frame status reads zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else if (flush)
    begin
      mem_q[0] <= '0; // RULE_07
      mem_q[1] <= '0;
    end
    else if (do_push)
      mem_q[wp_q] <= wdata; // RULE_04
  end
endmodule

// ===== hdl/urx_top.sv
`timescale 1ns/1ns
// ****************************************
// async receiver with avalon slave
// ****************************************
module urx_top
  import urx_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        SERIAL_RX_PIN,   // line from remote transmitter
  input  wire logic [3:0]  AVS_ADDRESS,     // byte address
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             IRQ              // registered request
);
  import urx_pkg::*;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [1:0]
  {
    URX_IDLE  = 2'b00,
    URX_START = 2'b01,
    URX_DATA  = 2'b11,
    URX_STOP  = 2'b10
  } urx_state_e;

  // ****************************************
  // registers
  // ****************************************
  logic        serial_port_enable_q;   // serial port enable
  logic        nine_bit_rx_select_q;   // nine bit select
  logic        continuous_rx_enable_q; // continuous rx enable
  logic        addr_detect_enable_q;   // address detect enable
  logic        overrun_flag_q;         // overrun flag
  logic        global_irq_enable_q;    // global irq enable
  logic        periph_irq_enable_q;    // peripheral irq enable
  logic        rx_irq_enable_q;        // rx irq enable
  logic [15:0] baud_q;                 // divisor
  logic        ack_q;                  // bus answer cycle
  logic        irq_q;                  // registered irq

  // ****************************************
  // synchroniser and shifter state
  // ****************************************
  logic [2:0]  sync_q;      // three stage input chain
  logic        rx_lvl_q;    // accepted line level
  urx_state_e  st_q;        // receive state
  logic [3:0]  tck_q;       // ticks within a bit
  logic [3:0]  bit_q;       // data bits taken
  logic [8:0]  shift_q;     // receive shift register
  logic        done_q;      // character complete pulse
  logic        frame_error_status_new_q;  // stop bit missing on this character

  // ****************************************
  // wires
  // ****************************************
  logic             tick;
  logic [URX_W-1:0] fifo_rd;
  logic             fifo_empty;
  logic             fifo_full;
  logic             push;
  logic             pop;
  logic             accept;
  logic             pending;
  logic             bus_rd;
  logic             bus_wr;
  logic             flush;
  logic [3:0]       nbits;
  logic [7:0]       ctrl_rd;
  logic [7:0]       irq_rd;

  assign bus_rd  = AVS_READ && !ack_q;
  assign bus_wr  = AVS_WRITE && !ack_q;
  assign flush   = !serial_port_enable_q;
  assign nbits   = nine_bit_rx_select_q ? 4'd9 : 4'd8;

  // ****************************************
  // baud tick and fifo
  // ****************************************
  urx_baud u_baud
  (
    .clk     (CORE_CLK),
    .rst_n   (RESETN),
    .run     (serial_port_enable_q),
    .divisor (baud_q),
    .tick    (tick)
  );

  urx_fifo u_fifo
  (
    .clk   (CORE_CLK),
    .rst_n (RESETN),
    .flush (flush),
    .push  (push),
    .wdata ({frame_error_status_new_q, shift_q}),
    .pop   (pop),
    .rdata (fifo_rd),
    .empty (fifo_empty),
    .full  (fifo_full)
  );

  // ****************************************
  // line input filter
  // ****************************************
  // three flops, level moves once stages two and three agree
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sync_q   <= 3'b111;
      rx_lvl_q <= 1'b1;
    end
    else
    begin
      sync_q <= {sync_q[1:0], SERIAL_RX_PIN};
      if (sync_q[1] == sync_q[2])
        rx_lvl_q <= sync_q[2];
    end
  end

  // ****************************************
  // receive state machine
  // ****************************************
  // runs on through framing errors; stops only on enables
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_q       <= URX_IDLE;
      tck_q      <= 4'h0;
      bit_q      <= 4'h0;
      shift_q    <= 9'h000;
      done_q     <= 1'b0;
      frame_error_status_new_q <= 1'b0;
    end
    else if (!serial_port_enable_q || !continuous_rx_enable_q)
    begin
      st_q   <= URX_IDLE; // receiver held in reset
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (tick)
      begin
        case (st_q)
          URX_IDLE:
          begin
            tck_q <= 4'h0;
            if (!rx_lvl_q)
              st_q <= URX_START;
          end
          URX_START:
          begin
            // mid start bit recheck rejects glitches
            if (tck_q == 4'(URX_MID))
            begin
              tck_q <= 4'h0;
              bit_q <= 4'h0;
              st_q  <= rx_lvl_q ? URX_IDLE : URX_DATA;
            end
            else
              tck_q <= tck_q + 4'h1;
          end
          URX_DATA:
          begin
            if (tck_q == 4'(URX_OVS - 1))
            begin
              tck_q <= 4'h0;
              // lsb first; ninth bit lands in bit 8
              if (nine_bit_rx_select_q)
                shift_q <= {rx_lvl_q, shift_q[8:1]}; // RULE_12
              else
                shift_q <= {1'b0, rx_lvl_q, shift_q[7:1]};
              bit_q <= bit_q + 4'h1;
              if (bit_q == nbits - 4'd1)
                st_q <= URX_STOP;
            end
            else
              tck_q <= tck_q + 4'h1;
          end
          URX_STOP:
          begin
            if (tck_q == 4'(URX_OVS - 1))
            begin
              tck_q      <= 4'h0;
              frame_error_status_new_q <= !rx_lvl_q; // RULE_04
              done_q     <= 1'b1;
              st_q       <= URX_IDLE; // RULE_06
            end
            else
              tck_q <= tck_q + 4'h1;
          end
          default:
            st_q <= URX_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // fifo admission
  // ****************************************
  // address filter, then overrun blocks everything; a same-cycle pop frees a slot
  assign accept = !addr_detect_enable_q || !nine_bit_rx_select_q || shift_q[8]; // RULE_15 RULE_19
  assign push   = done_q && accept && !overrun_flag_q && (!fifo_full || pop); // RULE_10
  assign pop    = bus_rd && (AVS_ADDRESS == URX_ADDR_DATA) && !fifo_empty; // RULE_05 RULE_22

  // ****************************************
  // overrun flag
  // ****************************************
  // a read in the same cycle frees a slot, so no overrun then
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      overrun_flag_q <= 1'b0;
    else if (!serial_port_enable_q || !continuous_rx_enable_q)
      overrun_flag_q <= 1'b0; // RULE_11
    else if (done_q && accept && fifo_full && !pop)
      overrun_flag_q <= 1'b1; // RULE_09
  end

  // ****************************************
  // pending flag and interrupt
  // ****************************************
  // pending follows occupancy while port and receiver are enabled, no software path
  assign pending = serial_port_enable_q && continuous_rx_enable_q
                   && !fifo_empty; // RULE_01 RULE_02 RULE_03 RULE_18

  // framing error has no term here
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      irq_q <= 1'b0;
    else
      irq_q <= pending && rx_irq_enable_q && periph_irq_enable_q
               && global_irq_enable_q; // RULE_03 RULE_08 RULE_18
  end
  assign IRQ = irq_q;

  // ****************************************
  // register writes
  // ****************************************
  // read-only status bits are dropped from write data
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      serial_port_enable_q   <= URX_CTRL_RST[URX_B_PORT_EN];
      nine_bit_rx_select_q   <= URX_CTRL_RST[URX_B_NINE_SEL];
      continuous_rx_enable_q <= URX_CTRL_RST[URX_B_RX_EN];
      addr_detect_enable_q   <= URX_CTRL_RST[URX_B_ADDR_DET];
      global_irq_enable_q    <= URX_IRQ_RST[2];
      periph_irq_enable_q    <= URX_IRQ_RST[1];
      rx_irq_enable_q        <= URX_IRQ_RST[0];
      baud_q                 <= URX_BAUD_RST;
    end
    else if (bus_wr)
    begin
      if (AVS_ADDRESS == URX_ADDR_CTRL && AVS_BYTEENABLE[0])
      begin
        serial_port_enable_q   <= AVS_WRITEDATA[URX_B_PORT_EN];
        nine_bit_rx_select_q   <= AVS_WRITEDATA[URX_B_NINE_SEL];
        continuous_rx_enable_q <= AVS_WRITEDATA[URX_B_RX_EN];
        addr_detect_enable_q   <= AVS_WRITEDATA[URX_B_ADDR_DET];
      end
      else if (AVS_ADDRESS == URX_ADDR_IRQ && AVS_BYTEENABLE[0])
      begin
        global_irq_enable_q <= AVS_WRITEDATA[URX_B_GLOBAL_IE];
        periph_irq_enable_q <= AVS_WRITEDATA[URX_B_PERIPH_IE];
        rx_irq_enable_q     <= AVS_WRITEDATA[URX_B_RX_IE];
      end
      else if (AVS_ADDRESS == URX_ADDR_BAUD)
      begin
        if (AVS_BYTEENABLE[0])
          baud_q[7:0] <= AVS_WRITEDATA[7:0];
        if (AVS_BYTEENABLE[1])
          baud_q[15:8] <= AVS_WRITEDATA[15:8];
      end
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // frame error and ninth bit from the oldest entry, zero when empty; overrun from its flag
  always_comb
  begin
    ctrl_rd = 8'h00;
    ctrl_rd[URX_B_PORT_EN]  = serial_port_enable_q;
    ctrl_rd[URX_B_NINE_SEL] = nine_bit_rx_select_q;
    ctrl_rd[URX_B_RX_EN]    = continuous_rx_enable_q;
    ctrl_rd[URX_B_ADDR_DET] = addr_detect_enable_q;
    ctrl_rd[URX_B_FRM_ERR]  = !fifo_empty && fifo_rd[9]; // RULE_05 RULE_21
    ctrl_rd[URX_B_OVERRUN]  = overrun_flag_q;
    ctrl_rd[URX_B_NINTH]    = !fifo_empty && fifo_rd[8]; // RULE_12
    irq_rd = 8'h00;
    irq_rd[URX_B_GLOBAL_IE] = global_irq_enable_q;
    irq_rd[URX_B_PERIPH_IE] = periph_irq_enable_q;
    irq_rd[URX_B_RX_IE]     = rx_irq_enable_q;
    irq_rd[URX_B_PEND]      = pending;
  end

  // one wait cycle, answer registered; unmapped reads zero
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_q        <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
      if (bus_rd)
      begin
        if (AVS_ADDRESS == URX_ADDR_CTRL)
          AVS_READDATA <= {24'h000000, ctrl_rd};
        else if (AVS_ADDRESS == URX_ADDR_DATA)
          AVS_READDATA <= {24'h000000, fifo_empty ? 8'h00 : fifo_rd[7:0]};
        else if (AVS_ADDRESS == URX_ADDR_IRQ)
          AVS_READDATA <= {24'h000000, irq_rd};
        else if (AVS_ADDRESS == URX_ADDR_BAUD)
          AVS_READDATA <= {16'h0000, baud_q};
        else
          AVS_READDATA <= 32'h0000_0000;
      end
    end
  end

  // waitrequest high except in the answer cycle
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_q);
  end
endmodule

// ===== tb/urx_tx_model.sv
`timescale 1ns/1ns
// ****************************************
// remote transmitter on the serial line
// ****************************************
module urx_tx_model
#(
  parameter int BIT_CLKS = 32 // clocks per bit, matches bench divisor
)
(
  input  wire logic clk,
  output logic      line  // idle high between frames
);
  initial line = 1'b1;
  // one frame, start low, lsb first, ninth bit last, bad drops the stop
  task automatic send(input logic [8:0] d, input logic nine, input logic bad);
    logic [10:0] f;
    int          n;
    n = nine ? 11 : 10;
    f = nine ? {!bad, d, 1'b0} : {1'b1, !bad, d[7:0], 1'b0};
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      line <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    // one idle bit so a dropped stop never looks like a start
    @(posedge clk);
    line <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
endmodule

// ===== tb/urx_top_assertions.sv
`timescale 1ns/1ns
// ****************************************
// port level checks for the receiver
// ****************************************
module urx_chk
  import urx_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RESETN,
  input wire logic        SERIAL_RX_PIN,
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        IRQ
);
  logic       done;    // access answered this cycle
  logic       rd_ctrl; // control read answered
  logic       rd_irq;  // irq register read answered
  logic       rd_dat;  // data read answered
  logic       wr_ctrl; // control write answered
  logic [7:0] ctrl_q;  // last control byte written
  logic [2:0] ien_q;   // last irq enables written
  logic       ovr_q;   // overrun seen, no disable since
  logic       pend_q;  // pending seen, no pop since
  logic       fresh_q; // fifo seen empty since last control write
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  assign done = (AVS_READ | AVS_WRITE) & !AVS_WAITREQUEST;
  assign rd_ctrl = done & AVS_READ & (AVS_ADDRESS == URX_ADDR_CTRL);
  assign rd_irq = done & AVS_READ & (AVS_ADDRESS == URX_ADDR_IRQ);
  assign rd_dat = done & AVS_READ & (AVS_ADDRESS == URX_ADDR_DATA);
  assign wr_ctrl = done & AVS_WRITE & (AVS_ADDRESS == URX_ADDR_CTRL) & AVS_BYTEENABLE[0];
  // shadows of what software wrote
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
    begin
      ctrl_q <= URX_CTRL_RST;
      ien_q  <= URX_IRQ_RST;
    end
    else if (wr_ctrl)
      ctrl_q <= AVS_WRITEDATA[7:0];
    else if (done & AVS_WRITE & (AVS_ADDRESS == URX_ADDR_IRQ) & AVS_BYTEENABLE[0])
      ien_q <= AVS_WRITEDATA[7:5];
  // status history seen on reads; a control write makes it stale
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
    begin
      ovr_q   <= 1'b0;
      pend_q  <= 1'b0;
      fresh_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      ovr_q   <= ovr_q & AVS_WRITEDATA[URX_B_RX_EN] & AVS_WRITEDATA[URX_B_PORT_EN];
      pend_q  <= 1'b0;
      fresh_q <= 1'b0;
    end
    else if (rd_ctrl & AVS_READDATA[URX_B_OVERRUN])
      ovr_q <= 1'b1;
    else if (rd_irq)
    begin
      pend_q  <= AVS_READDATA[URX_B_PEND];
      fresh_q <= fresh_q | !AVS_READDATA[URX_B_PEND];
    end
    else if (rd_dat)
      pend_q <= 1'b0;
  AST_IRQ_GATED: assert property (IRQ |-> &ien_q)
    else $error("request raised without all enables");
  AST_NOPEND_NOIRQ:
    assert property (rd_irq & !AVS_READDATA[URX_B_PEND] |-> ##[0:1] !IRQ)
    else $error("request with nothing pending");
  AST_IRQ_FOLLOW:
    assert property (rd_irq & AVS_READDATA[URX_B_PEND] & (&ien_q) |-> ##[0:1] IRQ)
    else $error("pending and enabled but no request");
  AST_OFF_EMPTY:
    assert property (rd_ctrl & !ctrl_q[URX_B_PORT_EN] |-> AVS_READDATA[2:0] == 3'h0)
    else $error("status bits set with port disabled");
  AST_OFF_NOPEND:
    assert property (rd_irq & !(ctrl_q[URX_B_PORT_EN] & ctrl_q[URX_B_RX_EN])
                     |-> !AVS_READDATA[URX_B_PEND])
    else $error("pending shown with receiver off");
  AST_OVR_STICKY: assert property (rd_ctrl & ovr_q |-> AVS_READDATA[URX_B_OVERRUN])
    else $error("overrun cleared without a disable");
  AST_ADDR_NINTH:
    assert property (rd_ctrl & fresh_q & pend_q & ctrl_q[URX_B_NINE_SEL]
                     & ctrl_q[URX_B_ADDR_DET] |-> AVS_READDATA[URX_B_NINTH])
    else $error("address mode character without ninth bit");
  AST_ACK_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer held longer than one cycle");
  AST_ACK_TIME: assert property ($rose(AVS_READ) || $rose(AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("access not answered in time");
endmodule
bind urx_top urx_chk chk_u (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .SERIAL_RX_PIN(SERIAL_RX_PIN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));

// ===== tb/tb.sv
`timescale 1ns/1ns
// ****************************************
// register level bench for the receiver
// ****************************************
module tb;
  import urx_pkg::*;
  logic        core_clk; // 125 MHz
  logic        resetn;
  logic        rx_line;  // driven by the transmitter model
  logic [3:0]  adr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        waitreq;
  logic        irq;
  logic [31:0] v;        // last read value
  int          errors;
  int          checks;
  urx_top dut_u (.CORE_CLK(core_clk), .RESETN(resetn), .SERIAL_RX_PIN(rx_line),
    .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq), .IRQ(irq));
  urx_tx_model #(.BIT_CLKS(32)) tx_u (.clk(core_clk), .line(rx_line));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; request held until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    adr   <= a;
    wdat  <= d;
    rd_en <= !w;
    wr_en <= w;
    do @(posedge core_clk); while (waitreq !== 1'b0);
    v = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    cmp(v & m, e);
  endtask
  task automatic rx(input logic [8:0] d, input logic nine, input logic bad);
    tx_u.send(d, nine, bad);
  endtask
  // hang guard, far beyond the longest expected run
  initial
  begin
    repeat (40000) @(posedge core_clk);
    errors++;
    summarize();
  end
  initial
  begin
    errors = 0;
    checks = 0;
    resetn = 1'b0;
    adr    = 4'h0;
    rd_en  = 1'b0;
    wr_en  = 1'b0;
    wdat   = 32'h0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    // reset values, then an unmapped hole
    rd_chk(URX_ADDR_CTRL, 32'hFF, 32'h0);
    rd_chk(URX_ADDR_IRQ, 32'hF0, 32'h0);
    rd_chk(URX_ADDR_BAUD, 32'hFFFF, {16'h0, URX_BAUD_RST});
    rd_chk(4'h2, 32'hFFFFFFFF, 32'h0);
    // setup order: divisor, port, enables, receiver last
    acc(1'b1, URX_ADDR_BAUD, 32'h1);
    acc(1'b1, URX_ADDR_CTRL, 32'h80);
    acc(1'b1, URX_ADDR_IRQ, 32'hF0);
    rd_chk(URX_ADDR_IRQ, 32'h10, 32'h0);
    acc(1'b1, URX_ADDR_CTRL, 32'h90);
    rx(9'h05A, 1'b0, 1'b0);
    cmp({31'h0, irq}, 32'h1);
    acc(1'b1, URX_ADDR_IRQ, 32'hE0);
    rd_chk(URX_ADDR_IRQ, 32'h10, 32'h10);
    // clearing each enable alone holds the request back
    for (int i = 5; i < 8; i++)
    begin
      acc(1'b1, URX_ADDR_IRQ, 32'hE0 & ~(32'h1 << i));
      repeat (2) @(posedge core_clk);
      cmp({31'h0, irq}, 32'h0);
      rd_chk(URX_ADDR_IRQ, 32'h10, 32'h10);
    end
    acc(1'b1, URX_ADDR_IRQ, 32'hE0);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h0);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'h5A);
    rd_chk(URX_ADDR_IRQ, 32'h10, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    // broken frame then a good one: status follows the oldest
    rx(9'h0C3, 1'b0, 1'b1);
    rx(9'h03C, 1'b0, 1'b0);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h4);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'hC3);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h0);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'h3C);
    // two broken frames keep the error shown across a pop
    rx(9'h011, 1'b0, 1'b1);
    rx(9'h022, 1'b0, 1'b1);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h4);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'h11);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h4);
    // receiver off keeps the error, port off clears it
    acc(1'b1, URX_ADDR_CTRL, 32'h80);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h4);
    acc(1'b1, URX_ADDR_CTRL, 32'h00);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h0);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'h0);
    acc(1'b1, URX_ADDR_CTRL, 32'h90);
    // four frames unread: third overruns, fourth is refused
    for (int i = 0; i < 4; i++)
      rx(9'h041 + 9'(i), 1'b0, 1'b0);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h2);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'h41);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'h42);
    rd_chk(URX_ADDR_IRQ, 32'h10, 32'h0);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h2);
    acc(1'b1, URX_ADDR_CTRL, 32'h80);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h0);
    // nine bit frames
    acc(1'b1, URX_ADDR_CTRL, 32'hD0);
    rx(9'h1A5, 1'b1, 1'b0);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h1);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'hA5);
    // address mode drops frames with the ninth bit clear
    acc(1'b1, URX_ADDR_CTRL, 32'hD8);
    rd_chk(URX_ADDR_IRQ, 32'h10, 32'h0);
    rx(9'h033, 1'b1, 1'b0);
    rd_chk(URX_ADDR_IRQ, 32'h10, 32'h0);
    rx(9'h1C3, 1'b1, 1'b0);
    rd_chk(URX_ADDR_IRQ, 32'h10, 32'h10);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h1);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'hC3);
    acc(1'b1, URX_ADDR_CTRL, 32'hD0);
    rx(9'h044, 1'b1, 1'b0);
    rd_chk(URX_ADDR_CTRL, 32'h7, 32'h0);
    rd_chk(URX_ADDR_DATA, 32'hFF, 32'h44);
    summarize();
  end
endmodule
